// ===== pkg/lefg_consts.svh
// offsets, field positions, reset values and timing counts of the event/launch block
// assumes byte addressing on a 32-bit axi4-lite slave
`ifndef LEFG_CONSTS_SVH
`define LEFG_CONSTS_SVH
`define LEFG_ADDR_EVENT_STATUS  8'h54
`define LEFG_ADDR_EVENT_MASK    8'h58
`define LEFG_ADDR_LAUNCH        8'h5c
`define LEFG_ADDR_SECONDS       8'h60
`define LEFG_ADDR_MODE          8'h64
`define LEFG_EVENT_RESET        32'h0000_0000
`define LEFG_EVENT_DEFINED      32'h01ff_fff8
`define LEFG_BIT_ASYNC_LAUNCH   0
`define LEFG_BIT_ISO_LAUNCH     1
`define LEFG_BIT_AUTO_RUN       2
`define LEFG_BIT_ASYNC_BUSY     8
`define LEFG_BIT_ISO_BUSY       9
`define LEFG_SECONDS_LOW_W      7
`define LEFG_CLK_MHZ            200
`define LEFG_MISS_TIME_US       250
`define LEFG_MISS_CYCLES        (`LEFG_MISS_TIME_US * `LEFG_CLK_MHZ)
`define LEFG_RESP_OKAY          2'b00
`define LEFG_RESP_SLVERR        2'b10
`endif

// ===== pkg/lefg_pkg.sv
// types of the event/launch block
// assumes the constants header is included by users
package lefg_pkg;
    typedef enum logic [2:0] {
        LEFG_ISO_NORMAL,
        LEFG_ISO_AUTO,
        LEFG_ISO_OTHER
    } lefg_iso_mode_t;
    typedef enum {
        LEFG_ISO_IDLE,
        LEFG_ISO_WAIT_CYCLE,
        LEFG_ISO_SENDING
    } lefg_iso_state_t;
endpackage

// ===== rtl/lefg_event_launch.sv
// event flags, event mask, transmit launch and bus seconds counter
// assumes event inputs are one-cycle pulses synchronous to aclk
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "lefg_consts.svh"
module lefg_event_launch #(
    parameter int unsigned MISS_CYCLES = `LEFG_MISS_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cycle_master,
    input  wire logic        cycle_start_rx,
    input  wire logic        cycle_over,
    input  wire logic        cycle_begin,
    input  wire logic        cycle_number_carry,
    input  wire logic [6:0]  cycle_seconds,
    input  wire logic        csr_reset_write,
    input  wire logic        rx_busy_acked,
    input  wire logic        rx_bad_header,
    input  wire logic        tx_bad_tcode,
    input  wire logic        tx_bad_ack,
    input  wire logic        phy_read_stored,
    input  wire logic        idle_gap_detect,
    input  wire logic        phy_bus_reset,
    input  wire logic        phy_interrupt,
    input  wire logic        shared_iso_discard,
    input  wire logic        iso_rx_discard,
    input  wire logic        auto_iso_miss,
    input  wire logic        iso_tx_finished,
    input  wire logic        async_rx_stored,
    input  wire logic        shared_iso_rx_stored,
    input  wire logic        iso_rx_stored,
    input  wire logic        async_tx_finished,
    input  wire logic        async_rx_discard,
    input  wire logic        auto_iso_run_pin,
    output logic             async_launch,
    output logic             iso_launch,
    output logic             iso_tx_active,
    output logic             auto_iso_run,
    output logic             irq_n
);
    logic [31:0]                  event_status;
    logic [31:0]                  event_mask;
    logic                         async_tx_busy;
    logic                         iso_tx_busy;
    logic                         auto_iso_run_bit;
    logic [24:0]                  bus_seconds_high;
    logic [2:0]                   iso_operating_mode;
    logic [31:0]                  miss_count;
    logic                         miss_armed;
    logic                         in_reset;
    logic                         aw_held;
    logic                         w_held;
    logic [7:0]                   aw_addr;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         wr_do;
    logic [31:0]                  event_set;
    logic                         missed_cycle;
    logic [31:0]                  seconds_merged;
    lefg_pkg::lefg_iso_state_t    iso_state;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // write channels taken in either order, response follows both
    assign wr_do = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_do) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LEFG_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                `LEFG_ADDR_EVENT_STATUS,
                `LEFG_ADDR_EVENT_MASK,
                `LEFG_ADDR_LAUNCH,
                `LEFG_ADDR_SECONDS,
                `LEFG_ADDR_MODE: s_axi_bresp <= `LEFG_RESP_OKAY;
                default:         s_axi_bresp <= `LEFG_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read side: one outstanding read, answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LEFG_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `LEFG_RESP_OKAY;
            case (s_axi_araddr)
                `LEFG_ADDR_EVENT_STATUS: s_axi_rdata <= event_status;
                `LEFG_ADDR_EVENT_MASK:   s_axi_rdata <= event_mask;
                `LEFG_ADDR_LAUNCH: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rdata[`LEFG_BIT_AUTO_RUN]   <= auto_iso_run_bit;
                    s_axi_rdata[`LEFG_BIT_ASYNC_BUSY] <= async_tx_busy;
                    s_axi_rdata[`LEFG_BIT_ISO_BUSY]   <= iso_tx_busy;
                end
                // low bits track the cycle timer seconds
                `LEFG_ADDR_SECONDS: s_axi_rdata <= {bus_seconds_high, cycle_seconds};
                `LEFG_ADDR_MODE:    s_axi_rdata <= {29'h000_0000, iso_operating_mode};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `LEFG_RESP_SLVERR;
                end
            endcase
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // missed cycle start watchdog, only when another node is master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            miss_armed <= 1'b0;
            miss_count <= 32'h0000_0000;
        end else if (cycle_master) begin
            miss_armed <= 1'b0;
        end else if (cycle_start_rx) begin
            miss_armed <= 1'b1;
            miss_count <= 32'h0000_0000;
        end else if (miss_armed) begin
            if (miss_count == MISS_CYCLES - 1) begin
                miss_armed <= 1'b0;
            end else begin
                miss_count <= miss_count + 32'h0000_0001;
            end
        end
    end
    assign missed_cycle = miss_armed && !cycle_master && !cycle_start_rx
                          && (miss_count == MISS_CYCLES - 1);

    always_comb begin
        event_set     = 32'h0000_0000;
        event_set[3]  = csr_reset_write;
        event_set[4]  = missed_cycle;
        event_set[5]  = cycle_over;
        event_set[6]  = cycle_begin;
        event_set[7]  = cycle_number_carry;
        event_set[8]  = rx_busy_acked;
        event_set[9]  = rx_bad_header;
        event_set[10] = tx_bad_tcode;
        event_set[11] = tx_bad_ack;
        event_set[12] = phy_read_stored;
        event_set[13] = idle_gap_detect && in_reset;
        event_set[14] = phy_bus_reset;
        event_set[15] = phy_interrupt;
        event_set[16] = shared_iso_discard;
        event_set[17] = iso_rx_discard;
        event_set[18] = auto_iso_miss && iso_operating_mode == 3'(lefg_pkg::LEFG_ISO_AUTO);
        event_set[19] = iso_tx_finished && iso_tx_busy;
        event_set[20] = async_rx_stored;
        event_set[21] = shared_iso_rx_stored;
        event_set[22] = iso_rx_stored;
        event_set[23] = async_tx_finished || (tx_bad_ack && async_tx_busy);
        event_set[24] = async_rx_discard;
    end

    // bus reset seen, waiting for the first idle gap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_reset <= 1'b0;
        end else if (phy_bus_reset) begin
            in_reset <= 1'b1;
        end else if (idle_gap_detect) begin
            in_reset <= 1'b0;
        end
    end

    // zero written clears, a set in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_status <= `LEFG_EVENT_RESET;
        end else begin
            if (wr_do && aw_addr == `LEFG_ADDR_EVENT_STATUS) begin
                event_status <= (merge_bytes(event_status, w_data, w_strb) & event_status
                                 | event_set) & `LEFG_EVENT_DEFINED;
            end else begin
                event_status <= (event_status | event_set) & `LEFG_EVENT_DEFINED;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_mask <= `LEFG_EVENT_RESET;
        end else if (wr_do && aw_addr == `LEFG_ADDR_EVENT_MASK) begin
            event_mask <= merge_bytes(event_mask, w_data, w_strb) & `LEFG_EVENT_DEFINED;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iso_operating_mode <= 3'(lefg_pkg::LEFG_ISO_NORMAL);
        end else if (wr_do && aw_addr == `LEFG_ADDR_MODE && w_strb[0]) begin
            iso_operating_mode <= w_data[2:0];
        end
    end

    // interrupt from flops, one cycle behind the flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~|(event_status & ~event_mask);
        end
    end

    // async launch; busy stays through retries until finish
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            async_tx_busy <= 1'b0;
            async_launch  <= 1'b0;
        end else begin
            async_launch <= 1'b0;
            if (async_tx_busy) begin
                if (async_tx_finished) begin
                    async_tx_busy <= 1'b0;
                end
            end else if (wr_do && aw_addr == `LEFG_ADDR_LAUNCH && w_strb[0]
                         && w_data[`LEFG_BIT_ASYNC_LAUNCH]) begin
                // buffer is assumed complete at this write
                async_tx_busy <= 1'b1;
                async_launch  <= 1'b1;
            end
        end
    end

    // iso launch only in normal mode, data waits for next cycle begin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iso_state     <= lefg_pkg::LEFG_ISO_IDLE;
            iso_tx_busy   <= 1'b0;
            iso_launch    <= 1'b0;
            iso_tx_active <= 1'b0;
        end else begin
            iso_launch <= 1'b0;
            case (iso_state)
                lefg_pkg::LEFG_ISO_IDLE: begin
                    if (wr_do && aw_addr == `LEFG_ADDR_LAUNCH && w_strb[0]
                        && w_data[`LEFG_BIT_ISO_LAUNCH]
                        && iso_operating_mode == 3'(lefg_pkg::LEFG_ISO_NORMAL)) begin
                        iso_tx_busy <= 1'b1;
                        iso_state   <= lefg_pkg::LEFG_ISO_WAIT_CYCLE;
                    end
                end
                lefg_pkg::LEFG_ISO_WAIT_CYCLE: begin
                    if (cycle_begin) begin
                        iso_launch    <= 1'b1;
                        iso_tx_active <= 1'b1;
                        iso_state     <= lefg_pkg::LEFG_ISO_SENDING;
                    end
                end
                lefg_pkg::LEFG_ISO_SENDING: begin
                    if (iso_tx_finished) begin
                        iso_tx_busy   <= 1'b0;
                        iso_tx_active <= 1'b0;
                        iso_state     <= lefg_pkg::LEFG_ISO_IDLE;
                    end
                end
                default: iso_state <= lefg_pkg::LEFG_ISO_IDLE;
            endcase
        end
    end

    // auto run: register bit or pin, only in auto mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_iso_run_bit <= 1'b0;
        end else if (wr_do && aw_addr == `LEFG_ADDR_LAUNCH && w_strb[0]) begin
            auto_iso_run_bit <= w_data[`LEFG_BIT_AUTO_RUN];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_iso_run <= 1'b0;
        end else begin
            auto_iso_run <= (auto_iso_run_bit || auto_iso_run_pin)
                            && iso_operating_mode == 3'(lefg_pkg::LEFG_ISO_AUTO);
        end
    end

    // low seven bits follow the timer input, so writes to them are dropped
    assign seconds_merged = merge_bytes({bus_seconds_high, 7'h00}, w_data, w_strb);

    // seconds extension; high part writable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_seconds_high <= 25'h00_0000;
        end else if (wr_do && aw_addr == `LEFG_ADDR_SECONDS) begin
            bus_seconds_high <= seconds_merged[31:7];
        end else if (cycle_number_carry && (&cycle_seconds)) begin
            bus_seconds_high <= bus_seconds_high + 25'h00_0001;
        end
    end
endmodule

// ===== sim/lefg_event_launch_chk.sv
// port assertions of the event/launch block
// assumes one clock domain, aresetn synchronous active low
`timescale 1ns/100ps
module lefg_event_launch_chk #(
    parameter int unsigned MISS_CYCLES = 20
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        cycle_begin,
    input wire logic        async_launch,
    input wire logic        iso_launch,
    input wire logic        iso_tx_active
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read data missing");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    refuse_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
        else $error("refused read carries data");
    no_new_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    iso_start_a: assert property (iso_launch |-> $past(cycle_begin))
        else $error("iso launch without cycle begin");
    async_pulse_a: assert property (async_launch |=> !async_launch)
        else $error("async launch longer than one cycle");
    iso_active_a: assert property (iso_launch |-> ##[0:1] iso_tx_active)
        else $error("iso send not active after launch");
endmodule
bind lefg_event_launch lefg_event_launch_chk #(.MISS_CYCLES(MISS_CYCLES)) chk_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cycle_begin, .async_launch,
    .iso_launch, .iso_tx_active
);

// ===== sim/lefg_host.sv
// host model: axi4-lite master, one register access per task call
// assumes the bench calls one task at a time
`timescale 1ns/100ps
module lefg_host (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0_0000_0000_0000;
    end
    // buffer filled before any launch write
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        join
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ===== sim/link_event_flags_and_tx_go_tb.sv
// self-checking bench of the event/launch block
// assumes the host model drives the register bus
`timescale 1ns/100ps
`include "lefg_consts.svh"
module link_event_flags_and_tx_go_tb;
    localparam int MISS = 20;
    localparam logic [7:0] ST = `LEFG_ADDR_EVENT_STATUS;
    localparam logic [7:0] MK = `LEFG_ADDR_EVENT_MASK;
    localparam logic [7:0] GO = `LEFG_ADDR_LAUNCH;
    localparam logic [7:0] SEC = `LEFG_ADDR_SECONDS;
    logic        aclk, aresetn, cycle_master, auto_iso_run_pin;
    logic [6:0]  cycle_seconds;
    logic [21:0] ev;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        async_launch, iso_launch, iso_tx_active, auto_iso_run, irq_n;
    int          bad_count = 0, num_checks = 0, cyc = 0, n_async = 0, n_iso = 0;
    // event input index in the high byte, status bit it should set in the low byte
    logic [15:0] rows[20] = '{16'h0003, 16'h0105, 16'h0206, 16'h0307, 16'h0408, 16'h0509,
        16'h060a, 16'h070b, 16'h080c, 16'h0a0e, 16'h090d, 16'h0b0f, 16'h0c10, 16'h0d11,
        16'h0e12, 16'h1014, 16'h1115, 16'h1216, 16'h1317, 16'h1418};
    lefg_host lefg_host_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    lefg_event_launch #(.MISS_CYCLES(MISS)) lefg_event_launch_i (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cycle_master, .cycle_start_rx(ev[21]),
        .cycle_over(ev[1]), .cycle_begin(ev[2]), .cycle_number_carry(ev[3]),
        .cycle_seconds, .csr_reset_write(ev[0]), .rx_busy_acked(ev[4]),
        .rx_bad_header(ev[5]), .tx_bad_tcode(ev[6]), .tx_bad_ack(ev[7]),
        .phy_read_stored(ev[8]), .idle_gap_detect(ev[9]), .phy_bus_reset(ev[10]),
        .phy_interrupt(ev[11]), .shared_iso_discard(ev[12]), .iso_rx_discard(ev[13]),
        .auto_iso_miss(ev[14]), .iso_tx_finished(ev[15]), .async_rx_stored(ev[16]),
        .shared_iso_rx_stored(ev[17]), .iso_rx_stored(ev[18]), .async_tx_finished(ev[19]),
        .async_rx_discard(ev[20]), .auto_iso_run_pin, .async_launch, .iso_launch,
        .iso_tx_active, .auto_iso_run, .irq_n);
    always #2.5 aclk = ~aclk;
    // hang guard: whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        n_async <= n_async + async_launch;
        n_iso <= n_iso + iso_launch;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
        lefg_host_i.rd(a, d, r);
        chk(n, d, e);
    endtask
    task automatic pulse(int i);
        @(posedge aclk);
        ev[i] <= 1'b1;
        @(posedge aclk);
        ev[i] <= 1'b0;
    endtask
    task automatic settle_chk(string n, logic s_exp);
        repeat (3) @(posedge aclk);
        chk(n, irq_n, s_exp);
    endtask
    task automatic run_chk(string n, logic s_exp);
        repeat (3) @(posedge aclk);
        chk(n, auto_iso_run, s_exp);
    endtask
    task summarize();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {aclk, aresetn, cycle_master, auto_iso_run_pin} = 4'h0;
        cycle_seconds = 7'h00;
        ev = 22'h00_0000;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[j]) rchk("reset value", 8'h54 + 8'(j % 4 * 4), 32'h0000_0000);
        chk("irq idle", irq_n, 1'b1);
        lefg_host_i.rd(8'h70, d, r);
        chk("unmapped read", {d[31:2], r}, {30'h0, 2'b10});
        lefg_host_i.wr(8'h70, 32'h0000_0000, r);
        chk("unmapped write", r, 2'b10);
        // missed auto transmit only counts in auto mode
        lefg_host_i.wr(`LEFG_ADDR_MODE, 32'(lefg_pkg::LEFG_ISO_AUTO), r);
        foreach (rows[j]) begin
            pulse(rows[j][15:8]);
            lefg_host_i.wr(ST, 32'hffff_ffff, r);
            rchk("event", ST, 32'h1 << rows[j][7:0]);
            lefg_host_i.wr(ST, 32'h0000_0000, r);
            rchk("cleared", ST, 32'h0000_0000);
        end
        lefg_host_i.wr(`LEFG_ADDR_MODE, 32'(lefg_pkg::LEFG_ISO_NORMAL), r);
        pulse(11);
        settle_chk("irq set", 1'b0);
        lefg_host_i.wr(MK, 32'h0000_8000, r);
        chk("write okay", r, 2'b00);
        settle_chk("irq masked", 1'b1);
        lefg_host_i.wr(MK, 32'h0000_0000, r);
        settle_chk("irq unmasked", 1'b0);
        lefg_host_i.wr(ST, 32'h0000_0000, r);
        settle_chk("irq cleared", 1'b1);
        lefg_host_i.wr(GO, 32'h0000_0000, r);
        lefg_host_i.wr(GO, 32'h0000_0001, r);
        lefg_host_i.wr(GO, 32'h0000_0001, r);
        rchk("async busy", GO, 32'h0000_0100);
        chk("async launches", n_async, 1);
        pulse(19);
        rchk("async idle", GO, 32'h0000_0000);
        lefg_host_i.wr(ST, 32'h0000_0000, r);
        lefg_host_i.wr(GO, 32'h0000_0002, r);
        repeat (4) @(posedge aclk);
        chk("iso waits", n_iso, 0);
        chk("iso not yet", iso_tx_active, 1'b0);
        pulse(2);
        rchk("iso busy", GO, 32'h0000_0200);
        chk("iso launch", n_iso, 1);
        chk("iso active", iso_tx_active, 1'b1);
        pulse(15);
        rchk("iso done", ST, 32'h0008_0040);
        rchk("iso idle", GO, 32'h0000_0000);
        chk("iso stopped", iso_tx_active, 1'b0);
        lefg_host_i.wr(`LEFG_ADDR_MODE, 32'(lefg_pkg::LEFG_ISO_AUTO), r);
        auto_iso_run_pin <= 1'b1;
        run_chk("pin run", 1'b1);
        auto_iso_run_pin <= 1'b0;
        lefg_host_i.wr(GO, 32'h0000_0004, r);
        run_chk("bit run", 1'b1);
        lefg_host_i.wr(GO, 32'h0000_0006, r);
        rchk("auto iso go", GO, 32'h0000_0004);
        lefg_host_i.wr(GO, 32'h0000_0000, r);
        run_chk("run stop", 1'b0);
        cycle_seconds <= 7'h7f;
        pulse(3);
        rchk("seconds", SEC, 32'h0000_00ff);
        lefg_host_i.wr(SEC, 32'h0000_0000, r);
        rchk("seconds low", SEC, 32'h0000_007f);
        lefg_host_i.wr(ST, 32'h0000_0000, r);
        pulse(21);
        repeat (10) @(posedge aclk);
        pulse(21);
        repeat (12) @(posedge aclk);
        rchk("cycle kept", ST, 32'h0000_0000);
        repeat (12) @(posedge aclk);
        rchk("cycle missed", ST, 32'h0000_0010);
        cycle_master <= 1'b1;
        lefg_host_i.wr(ST, 32'h0000_0000, r);
        pulse(21);
        repeat (30) @(posedge aclk);
        rchk("master quiet", ST, 32'h0000_0000);
        pulse(11);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("reset clears", ST, 32'h0000_0000);
        chk("irq after reset", irq_n, 1'b1);
        summarize();
    end
endmodule
